// [verilog/smp_consts.svh]
`ifndef SMP_CONSTS_SVH
`define SMP_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMP_CLK_HZ 10000000
`define SMP_T_POR_MS 10
`define SMP_T_PINRST_US 100
`define SMP_POR_CYCLES (`SMP_T_POR_MS * (`SMP_CLK_HZ / 1000))
`define SMP_PINRST_CYCLES (`SMP_T_PINRST_US * (`SMP_CLK_HZ / 1000000))

// ----------------------------------------------------------------
// Supply limits in millivolts
// ----------------------------------------------------------------
`define SMP_VDD_UV_MV 16'd4500
`define SMP_VDD_OV_MV 16'd5500
`define SMP_VIO3_UV_MV 16'd3000
`define SMP_VIO3_OV_MV 16'd3600
`define SMP_VIO5_UV_MV 16'd4500
`define SMP_VIO5_OV_MV 16'd5500
// Battery code carries three more fraction bits than a limit field.
`define SMP_VBAT_FRAC_BITS 3

// ----------------------------------------------------------------
// External supply diagnostic bits
// ----------------------------------------------------------------
`define SMP_EXT_VDD_UV 0
`define SMP_EXT_VDD_OV 1
`define SMP_EXT_VIO_UV 2
`define SMP_EXT_VIO_OV 3
`define SMP_EXT_VBAT_UV 4
`define SMP_EXT_VBAT_OV 5
`define SMP_EXT_POR_EVENT 6
`define SMP_EXT_PIN_EVENT 7
`define SMP_EXT_RESET 8'h80
`define SMP_EXT_SUM_MASK 8'h3f

// ----------------------------------------------------------------
// Internal supply diagnostic bits
// ----------------------------------------------------------------
`define SMP_INT_V2V5_UV 0
`define SMP_INT_V2V5_OV 1
`define SMP_INT_IREF_UV 2
`define SMP_INT_IREF_OV 3
`define SMP_INT_PREREG_OV 4
`define SMP_INT_REF_UV 5
`define SMP_INT_REF_OV 6
`define SMP_INT_RESET 7'h00
`define SMP_INT_SUM_MASK 7'h7f

`define SMP_CHAN_RESET 6'h00

`endif

// [verilog/smp_pkg.sv]
package smp_pkg;

  typedef logic [15:0] smp_vcode_t;
  typedef logic [10:0] smp_bcode_t;
  typedef logic [16:0] smp_count_t;

  typedef enum logic [1:0] {
    SMP_PIN_WAIT = 2'b00,
    SMP_POR_HOLD = 2'b01,
    SMP_SETUP = 2'b10,
    SMP_MISSION = 2'b11
  } smp_state_e;

  typedef struct packed {
    smp_state_e state;
    smp_count_t count;
    logic [5:0] enables;
    logic powerStageOff;
    logic forceSetup;
    logic logicReady;
    logic [31:0] ioCore;
    smp_bcode_t vbat;
  } smp_top_s;

  // Returns {over, under} for a code against a window.
  function automatic logic [1:0] smp_window(
    input logic [15:0] code,
    input logic [15:0] low,
    input logic [15:0] high
  );
    smp_window = {code > high, code < low};
  endfunction

endpackage

// [verilog/smp_flag_bank.sv]
`timescale 1ns/1ps
module smp_flag_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] SUM_MASK = '1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] setEvents,
  input wire logic clearWe,
  input wire logic [WIDTH-1:0] clearMask,
  output logic [WIDTH-1:0] flags,
  output logic anyFlag
);
  import smp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
    logic anyFlag;
  } smp_bank_s;

  smp_bank_s bank_reg;
  smp_bank_s bank_next;

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // A set in the clearing cycle survives, so a fault that is still
  // present is never lost to a write that raced it.
  always_comb
  begin
    bank_next = bank_reg;
    bank_next.flags = (bank_reg.flags & ~(clearWe ? clearMask : '0)) | setEvents;
    bank_next.anyFlag = |(bank_next.flags & SUM_MASK);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      bank_reg.flags <= RESET_VALUE;
      bank_reg.anyFlag <= |(RESET_VALUE & SUM_MASK);
    end
    else
    begin
      bank_reg <= bank_next;
    end
  end

  assign flags = bank_reg.flags;
  assign anyFlag = bank_reg.anyFlag;

endmodule

// [verilog/smp_supply_monitor.sv]
`timescale 1ns/1ps
`include "smp_consts.svh"
module smp_supply_monitor #(
  parameter int unsigned POR_CYCLES = `SMP_POR_CYCLES
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic measValid,
  input wire smp_pkg::smp_vcode_t vddCode,
  input wire smp_pkg::smp_vcode_t vioCode,
  input wire smp_pkg::smp_bcode_t vbatCode,
  input wire logic [6:0] internalDetect,
  input wire logic coreLogicSupplyLow,
  input wire logic [7:0] batteryLowLimit,
  input wire logic [7:0] batteryHighLimit,
  input wire logic ioSupplyLevelSelect,
  input wire logic monitorSelftestSwap,
  input wire logic coreRailHighResetTest,
  input wire logic coreRailLowResetTest,
  input wire logic missionRequest,
  input wire logic setupRequest,
  input wire logic channelEnableWe,
  input wire logic [5:0] channelEnableWdata,
  input wire logic extDiagClearWe,
  input wire logic [7:0] extDiagClearMask,
  input wire logic intDiagClearWe,
  input wire logic [6:0] intDiagClearMask,
  output logic [5:0] channelEnableBits,
  output logic [7:0] externalSupplyDiagRegister,
  output logic [6:0] internalSupplyDiagRegister,
  output logic externalSupplyFaultSummary,
  output logic internalSupplyFaultSummary,
  output logic [31:0] ioCoreVoltageReadback,
  output smp_pkg::smp_bcode_t batteryVoltageReadback,
  output logic powerStageOff,
  output logic forceSetup,
  output logic logicReady,
  output smp_pkg::smp_state_e deviceState
);
  import smp_pkg::*;

  smp_top_s top_reg;
  smp_top_s top_next;

  logic [1:0] vddHit;
  logic [1:0] vioHit;
  logic [1:0] vbatHit;
  logic [15:0] vioLow;
  logic [15:0] vioHigh;
  smp_bcode_t vbatLow;
  smp_bcode_t vbatHigh;
  logic [7:0] extLive;
  logic [6:0] intLive;
  logic [7:0] extSet;
  logic porCause;
  logic supplyOk;
  logic chanFault;
  logic setupFault;
  logic coreFault;
  logic ioFault;
  logic countDone;
  logic pinWaitDone;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Each supply owns an adjacent pair of detector bits, under first.
  function automatic logic smp_pair_fault(
    input logic [7:0] live,
    input int unsigned lowBit
  );
    smp_pair_fault = live[lowBit] | live[lowBit + 1];
  endfunction

  // States in which the host may talk to the block.
  function automatic logic smp_host_state(
    input smp_state_e state
  );
    smp_host_state = state == SMP_SETUP || state == SMP_MISSION;
  endfunction

  // ----------------------------------------------------------------
  // Limit selection
  // ----------------------------------------------------------------
  always_comb
  begin
    // Only the I/O pair follows the level select; the core rail
    // always runs at 5 V, so its pair is fixed.
    if (ioSupplyLevelSelect)
    begin
      vioLow = `SMP_VIO5_UV_MV;
      vioHigh = `SMP_VIO5_OV_MV;
    end
    else
    begin
      vioLow = `SMP_VIO3_UV_MV;
      vioHigh = `SMP_VIO3_OV_MV;
    end
    // The limit field is scaled into the battery code's finer step.
    vbatLow = {batteryLowLimit, `SMP_VBAT_FRAC_BITS'(0)};
    vbatHigh = {batteryHighLimit, `SMP_VBAT_FRAC_BITS'(0)};
  end

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  always_comb
  begin
    // Limits compare strictly, so a code equal to a limit is still good.
    vddHit = smp_window(vddCode, `SMP_VDD_UV_MV, `SMP_VDD_OV_MV);
    vioHit = smp_window(vioCode, vioLow, vioHigh);
    vbatHit = smp_window(
      {5'h00, vbatCode},
      {5'h00, vbatLow},
      {5'h00, vbatHigh}
    );
    extLive = 8'h00;
    extLive[`SMP_EXT_VDD_UV] = vddHit[0];
    extLive[`SMP_EXT_VDD_OV] = vddHit[1];
    extLive[`SMP_EXT_VIO_UV] = vioHit[0];
    extLive[`SMP_EXT_VIO_OV] = vioHit[1];
    extLive[`SMP_EXT_VBAT_UV] = vbatHit[0];
    extLive[`SMP_EXT_VBAT_OV] = vbatHit[1];
    intLive = internalDetect;
    // Self test forces every detector bit high past the comparators, which
    // proves each detector flag path (not the event bits 6 and 7) can report a fault.
    if (monitorSelftestSwap)
    begin
      extLive = extLive | `SMP_EXT_SUM_MASK;
      intLive = intLive | `SMP_INT_SUM_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Fault consequences
  // ----------------------------------------------------------------
  always_comb
  begin
    // Battery faults never drop the stages or enables; they raise flags and hold off release from reset.
    coreFault = smp_pair_fault(extLive, `SMP_EXT_VDD_UV);
    ioFault = smp_pair_fault(extLive, `SMP_EXT_VIO_UV);
    chanFault = coreFault
      | ioFault
      | (|intLive);
    // The pre-regulator overvoltage drops the enables through chanFault
    // but leaves the state alone.
    setupFault = coreFault
      | ioFault
      | (|(intLive & ~(7'h01 << `SMP_INT_PREREG_OV)));
    supplyOk = ~(|(extLive & `SMP_EXT_SUM_MASK)) & ~(|intLive)
      & ~coreLogicSupplyLow;
    porCause = coreLogicSupplyLow | coreRailHighResetTest | coreRailLowResetTest;
    extSet = extLive & `SMP_EXT_SUM_MASK;
    extSet[`SMP_EXT_POR_EVENT] = porCause;
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    countDone = top_reg.count == 17'(POR_CYCLES - 1);
    pinWaitDone = top_reg.count == 17'(`SMP_PINRST_CYCLES - 1);
    top_next = top_reg;
    unique case (top_reg.state)
      SMP_PIN_WAIT:
      begin
        // The host sees logicReady low for the whole wait and must not
        // access the block before it ends.
        top_next.count = top_reg.count + 17'd1;
        if (pinWaitDone)
        begin
          top_next.count = 17'd0;
          top_next.state = supplyOk ? SMP_SETUP : SMP_POR_HOLD;
        end
      end
      SMP_POR_HOLD:
      begin
        // The delay restarts whenever any supply leaves its range.
        top_next.count = supplyOk ? top_reg.count + 17'd1 : 17'd0;
        if (supplyOk && countDone)
        begin
          top_next.count = 17'd0;
          top_next.state = SMP_SETUP;
        end
      end
      SMP_SETUP:
      begin
        // A request made during a setup-class fault is dropped, not
        // queued, so the host must ask again once the fault is gone.
        if (missionRequest && !setupFault)
        begin
          top_next.state = SMP_MISSION;
        end
      end
      SMP_MISSION:
      begin
        if (setupFault || setupRequest)
        begin
          top_next.state = SMP_SETUP;
        end
      end
    endcase
    // A reset cause overrides any transition above, so even a short
    // test pulse restarts the full hold time.
    if (porCause)
    begin
      top_next.state = SMP_POR_HOLD;
      top_next.count = 17'd0;
    end

    // ----------------------------------------------------------------
    // Channel enables and status
    // ----------------------------------------------------------------
    // Channel enables are accepted only when the next state is mission; in any other
    // cycle the write is dropped rather than held for later.
    if (channelEnableWe && top_next.state == SMP_MISSION)
    begin
      top_next.enables = channelEnableWdata;
    end
    if (top_next.state != SMP_MISSION)
    begin
      top_next.enables = `SMP_CHAN_RESET;
    end
    if (chanFault)
    begin
      top_next.enables = `SMP_CHAN_RESET;
    end

    top_next.powerStageOff = coreFault | (top_next.state != SMP_MISSION);
    top_next.forceSetup = setupFault;
    top_next.logicReady = smp_host_state(top_next.state);

    // Readbacks keep their last sample while no conversion is valid.
    if (measValid)
    begin
      top_next.ioCore = {vioCode, vddCode};
      top_next.vbat = vbatCode;
    end
  end

  // Pin reset returns every register to default and stages off.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      top_reg.state <= SMP_PIN_WAIT;
      top_reg.count <= 17'd0;
      top_reg.enables <= `SMP_CHAN_RESET;
      top_reg.powerStageOff <= 1'b1;
      top_reg.forceSetup <= 1'b0;
      top_reg.logicReady <= 1'b0;
      top_reg.ioCore <= 32'h0000_0000;
      top_reg.vbat <= 11'h000;
    end
    else
    begin
      top_reg <= top_next;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic flag banks
  // ----------------------------------------------------------------
  smp_flag_bank #(
    .WIDTH(8),
    .RESET_VALUE(`SMP_EXT_RESET),
    .SUM_MASK(`SMP_EXT_SUM_MASK)
  ) u_ext_flags (
    .mclk(mclk),
    .nrst(nrst),
    .setEvents(extSet),
    .clearWe(extDiagClearWe),
    .clearMask(extDiagClearMask),
    .flags(externalSupplyDiagRegister),
    .anyFlag(externalSupplyFaultSummary)
  );

  smp_flag_bank #(
    .WIDTH(7),
    .RESET_VALUE(`SMP_INT_RESET),
    .SUM_MASK(`SMP_INT_SUM_MASK)
  ) u_int_flags (
    .mclk(mclk),
    .nrst(nrst),
    .setEvents(intLive),
    .clearWe(intDiagClearWe),
    .clearMask(intDiagClearMask),
    .flags(internalSupplyDiagRegister),
    .anyFlag(internalSupplyFaultSummary)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop, so nothing combinational reaches a pin.
  assign channelEnableBits = top_reg.enables;
  assign ioCoreVoltageReadback = top_reg.ioCore;
  assign batteryVoltageReadback = top_reg.vbat;
  assign powerStageOff = top_reg.powerStageOff;
  assign forceSetup = top_reg.forceSetup;
  assign logicReady = top_reg.logicReady;
  assign deviceState = top_reg.state;

endmodule

// [verif/smp_checker.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Supply monitor checker
// ----------------------------------------------------------------
module smp_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire smp_pkg::smp_vcode_t vddCode,
  input wire logic [6:0] internalDetect,
  input wire logic coreLogicSupplyLow,
  input wire logic monitorSelftestSwap,
  input wire logic coreRailHighResetTest,
  input wire logic coreRailLowResetTest,
  input wire logic extDiagClearWe,
  input wire logic [7:0] extDiagClearMask,
  input wire logic [5:0] channelEnableBits,
  input wire logic [7:0] externalSupplyDiagRegister,
  input wire logic [6:0] internalSupplyDiagRegister,
  input wire logic externalSupplyFaultSummary,
  input wire logic internalSupplyFaultSummary,
  input wire logic powerStageOff,
  input wire logic forceSetup,
  input wire logic logicReady,
  input wire smp_pkg::smp_state_e deviceState
);
  import smp_pkg::*;
  logic [10:0] relCnt_reg;
  // Counts edges since pin reset release and saturates, so it never wraps into a false check.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      relCnt_reg <= 11'h000;
    else if (relCnt_reg != 11'h7ff)
      relCnt_reg <= relCnt_reg + 11'h001;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_VDD_FLAG: assert property (vddCode < 16'h1194 |=> externalSupplyDiagRegister[0])
    else $error("core undervoltage flag missing");
  AST_CORE_OFF: assert property ((vddCode < 16'h1194 || vddCode > 16'h157c) |=>
    powerStageOff && channelEnableBits == 6'h00) else $error("stages on with core fault");
  AST_STICKY: assert property (externalSupplyDiagRegister[0] &&
    !(extDiagClearWe && extDiagClearMask[0]) |=> externalSupplyDiagRegister[0])
    else $error("flag dropped without write");
  AST_REFLAG: assert property (extDiagClearWe && extDiagClearMask[0] &&
    vddCode < 16'h1194 |=> externalSupplyDiagRegister[0]) else $error("persisting fault lost");
  AST_INT_FLAG: assert property (|internalDetect |=>
    (internalSupplyDiagRegister & $past(internalDetect)) == $past(internalDetect))
    else $error("internal flag missing");
  AST_SUMS: assert property (internalSupplyFaultSummary == (|internalSupplyDiagRegister) &&
    externalSupplyFaultSummary == (|externalSupplyDiagRegister[5:0])) else $error("summary wrong");
  AST_SWAP: assert property (monitorSelftestSwap |=> externalSupplyDiagRegister[5:0] == 6'h3f
    && internalSupplyDiagRegister == 7'h7f) else $error("self test flags missing");
  AST_POR: assert property ((coreLogicSupplyLow || coreRailHighResetTest ||
    coreRailLowResetTest) |=> deviceState == SMP_POR_HOLD && !logicReady &&
    externalSupplyDiagRegister[6]) else $error("reset hold missing");
  AST_SETUP_EN: assert property (deviceState != SMP_MISSION |-> channelEnableBits == 6'h00)
    else $error("enables outside mission");
  AST_PIN_RELEASE: assert property (relCnt_reg == 11'h3e8 |-> deviceState != SMP_PIN_WAIT)
    else $error("pin reset release late");
  AST_MIS_FAULT: assert property (deviceState == SMP_MISSION && |internalDetect[3:0] |=>
    deviceState == SMP_SETUP) else $error("no setup entry");
  AST_FORCE_SETUP: assert property ((vddCode < 16'h1194 ||
    (internalDetect & 7'h6f) != 7'h00) |=> forceSetup) else $error("setup flag missing");
  cover property (deviceState == SMP_MISSION && channelEnableBits == 6'h3f);
  cover property ($rose(externalSupplyDiagRegister[6]));
  cover property (monitorSelftestSwap);
endmodule
bind smp_supply_monitor smp_checker u_chk (.mclk, .nrst, .vddCode, .internalDetect,
  .coreLogicSupplyLow, .monitorSelftestSwap, .coreRailHighResetTest, .coreRailLowResetTest,
  .extDiagClearWe, .extDiagClearMask, .channelEnableBits, .externalSupplyDiagRegister,
  .internalSupplyDiagRegister, .externalSupplyFaultSummary, .internalSupplyFaultSummary,
  .powerStageOff, .forceSetup, .logicReady, .deviceState);

// [verif/smp_supply_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Converter stand-in
// ----------------------------------------------------------------
module smp_supply_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [15:0] vddMv,
  input wire logic [15:0] vioMv,
  input wire smp_pkg::smp_bcode_t vbatSet,
  input wire logic [6:0] detSet,
  output logic measValid,
  output smp_pkg::smp_vcode_t vddCode,
  output smp_pkg::smp_vcode_t vioCode,
  output smp_pkg::smp_bcode_t vbatCode,
  output logic [6:0] internalDetect
);
  import smp_pkg::*;
  // Results lag the analog level by one conversion, so no fault is seen in the cycle it starts.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      measValid <= 1'b0;
      {vddCode, vioCode, vbatCode, internalDetect} <= {16'h1388, 16'h0ce4, 11'h250, 7'h00};
    end
    else
    begin
      measValid <= 1'b1;
      {vddCode, vioCode, vbatCode, internalDetect} <= {vddMv, vioMv, vbatSet, detSet};
    end
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module tb_top;
  import smp_pkg::*;
  localparam int POR = 20;
  logic mclk, nrst, measValid, coreLogicSupplyLow, ioSupplyLevelSelect, monitorSelftestSwap;
  logic coreRailHighResetTest, coreRailLowResetTest, missionRequest, setupRequest;
  logic channelEnableWe, extDiagClearWe, intDiagClearWe, extSum, intSum, powerStageOff, logicReady;
  logic fs;
  logic [5:0] channelEnableWdata, en;
  logic [6:0] detSet, internalDetect, intDiagClearMask, intd;
  logic [7:0] batteryLowLimit, batteryHighLimit, extDiagClearMask, ext;
  logic [15:0] vddMv, vioMv;
  logic [31:0] ioCoreVoltageReadback;
  smp_vcode_t vddCode, vioCode;
  smp_bcode_t vbatSet, vbatCode, batteryVoltageReadback;
  smp_state_e st;
  int n_fail = 0;
  int n_tests = 0;
  smp_supply_model model (.mclk, .nrst, .vddMv, .vioMv, .vbatSet, .detSet, .measValid,
    .vddCode, .vioCode, .vbatCode, .internalDetect);
  smp_supply_monitor #(.POR_CYCLES(POR)) uut (.mclk, .nrst, .measValid, .vddCode, .vioCode,
    .vbatCode, .internalDetect, .coreLogicSupplyLow, .batteryLowLimit, .batteryHighLimit,
    .ioSupplyLevelSelect, .monitorSelftestSwap, .coreRailHighResetTest, .coreRailLowResetTest,
    .missionRequest, .setupRequest, .channelEnableWe, .channelEnableWdata, .extDiagClearWe,
    .extDiagClearMask, .intDiagClearWe, .intDiagClearMask, .channelEnableBits(en),
    .externalSupplyDiagRegister(ext), .internalSupplyDiagRegister(intd),
    .externalSupplyFaultSummary(extSum), .internalSupplyFaultSummary(intSum),
    .ioCoreVoltageReadback, .batteryVoltageReadback, .powerStageOff, .forceSetup(fs),
    .logicReady, .deviceState(st));
  always #50 mclk = ~mclk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic clr;
    {extDiagClearWe, intDiagClearWe, extDiagClearMask, intDiagClearMask} = {2'b11, 15'h7fff};
    tick();
    {extDiagClearWe, intDiagClearWe} = 2'b00;
    tick();
  endtask
  // Bounded wait, so a design that never becomes ready ends in a mismatch, not a hang.
  task automatic wrdy(output int w);
    w = 0;
    while (logicReady !== 1'b1 && w < 2000)
    begin
      tick();
      w++;
    end
  endtask
  task automatic wen(input logic [5:0] d);
    {channelEnableWe, channelEnableWdata} = {1'b1, d};
    tick();
    channelEnableWe = 1'b0;
    tick();
  endtask
  task automatic mis;
    missionRequest = 1'b1;
    tick(2);
    missionRequest = 1'b0;
    wen(6'h3f);
  endtask
  task automatic t_reset;
    int w;
    chk(ext === 8'h80 && en === 6'h00 && st === SMP_PIN_WAIT, "reset values");
    nrst = 1'b1;
    wrdy(w);
    chk(w <= 1001 && st === SMP_SETUP, "late release");
    chk(ioCoreVoltageReadback === 32'h0ce41388, "io readback");
    chk(batteryVoltageReadback === 11'h250, "battery readback");
    wen(6'h3f);
    chk(en === 6'h00, "enable taken in setup");
    mis;
    chk(en === 6'h3f && st === SMP_MISSION, "mission enable");
  endtask
  task automatic t_ext(input logic [15:0] vd, vi, input logic [10:0] vb, input logic sel,
    input logic [5:0] exp, input logic keep);
    mis;
    {vddMv, vioMv, vbatSet, ioSupplyLevelSelect} = {vd, vi, vb, sel};
    tick(3);
    chk(ext[5:0] === exp && extSum === (exp != 6'h00), "supply flag");
    chk(en === (keep ? 6'h3f : 6'h00) && (st === SMP_MISSION) === keep, "action");
    chk(powerStageOff === !keep && fs === !keep, "stage state");
    {vddMv, vioMv, vbatSet} = {16'h1388, 16'h0ce4, 11'h250};
    tick(2);
    ioSupplyLevelSelect = 1'b0;
    tick();
    chk(ext[5:0] === exp, "flag not sticky");
    clr;
    chk(ext === 8'h00, "flag not cleared");
  endtask
  task automatic t_int;
    logic [6:0] b;
    for (int i = 0; i < 7; i++)
    begin
      b = 7'h01 << i;
      mis;
      detSet = b;
      tick(3);
      chk(intd === b && intSum === 1'b1, "internal flag");
      chk(en === 6'h00, "enable kept");
      chk((st === SMP_MISSION) === (i == 4) && fs === (i != 4), "setup entry");
      detSet = 7'h00;
      tick(2);
      clr;
    end
  endtask
  task automatic t_por;
    int w;
    for (int k = 0; k < 3; k++)
    begin
      clr;
      {coreLogicSupplyLow, coreRailLowResetTest, coreRailHighResetTest} = 3'b001 << k;
      tick();
      {coreLogicSupplyLow, coreRailLowResetTest, coreRailHighResetTest} = 3'b000;
      chk(st === SMP_POR_HOLD && logicReady === 1'b0 && ext[6] === 1'b1, "no hold");
      wrdy(w);
      chk(w >= POR - 1 && w <= POR + 2 && st === SMP_SETUP, "hold time");
      chk(ext[6] === 1'b1, "event lost");
    end
  endtask
  task automatic t_pin;
    int w;
    mis;
    setupRequest = 1'b1;
    tick();
    setupRequest = 1'b0;
    chk(st === SMP_SETUP && en === 6'h00 && fs === 1'b0, "setup request");
    mis;
    nrst = 1'b0;
    tick(3);
    chk(en === 6'h00 && ext === 8'h80 && intd === 7'h00 && st === SMP_PIN_WAIT, "pin reset");
    chk(ioCoreVoltageReadback === 32'h0 && batteryVoltageReadback === 11'h000, "pin readback");
    chk(powerStageOff === 1'b1 && logicReady === 1'b0, "pin stage state");
    nrst = 1'b1;
    wrdy(w);
    chk(w <= 1001 && st === SMP_SETUP, "late release after pin reset");
  endtask
  initial
  begin
    {mclk, nrst, coreLogicSupplyLow, ioSupplyLevelSelect, monitorSelftestSwap,
      coreRailHighResetTest, coreRailLowResetTest, missionRequest, setupRequest, channelEnableWe,
      extDiagClearWe, intDiagClearWe, channelEnableWdata, extDiagClearMask, intDiagClearMask} = '0;
    {vddMv, vioMv, vbatSet, detSet} = {16'h1388, 16'h0ce4, 11'h250, 7'h00};
    {batteryLowLimit, batteryHighLimit} = {8'h25, 8'h6f};
    tick(16);
    t_reset;
    t_ext(16'h1193, 16'h0ce4, 11'h250, 1'b0, 6'h01, 1'b0);
    t_ext(16'h157d, 16'h0ce4, 11'h250, 1'b0, 6'h02, 1'b0);
    t_ext(16'h1388, 16'h0bb7, 11'h250, 1'b0, 6'h04, 1'b0);
    t_ext(16'h1388, 16'h0e11, 11'h250, 1'b0, 6'h08, 1'b0);
    t_ext(16'h1388, 16'h0fa0, 11'h250, 1'b1, 6'h04, 1'b0);
    t_ext(16'h1388, 16'h1388, 11'h250, 1'b0, 6'h08, 1'b0);
    t_ext(16'h1388, 16'h0ce4, 11'h127, 1'b0, 6'h10, 1'b1);
    t_ext(16'h1388, 16'h0ce4, 11'h128, 1'b0, 6'h00, 1'b1);
    t_ext(16'h1388, 16'h0ce4, 11'h379, 1'b0, 6'h20, 1'b1);
    t_int;
    monitorSelftestSwap = 1'b1;
    tick(2);
    chk(ext[5:0] === 6'h3f && intd === 7'h7f, "self test");
    monitorSelftestSwap = 1'b0;
    tick();
    t_por;
    t_pin;
    give_verdict;
  end
  initial
  begin
    #1000000;
    n_fail++;
    give_verdict;
  end
endmodule
